// [sim/rfc_host.sv]
// Host model: an Avalon-MM master that moves one word per request.
// Assumes a registered waitrequest slave on the same clock as clk_i.
`timescale 1ns/1ps
module rfc_host
    import rfc_pkg::*;
(
    // clock
    input wire logic clk_i,
    // avalon-mm master
    output logic [ADDR_W-1:0] address_o,
    output logic read_o,
    output logic write_o,
    output logic [DATA_W-1:0] writedata_o,
    output logic [BE_W-1:0] byteenable_o,
    input wire logic [DATA_W-1:0] readdata_i,
    input wire logic waitrequest_i,
    // wait bound used up
    output logic stuck_o
);
    initial begin
        address_o = '0;
        read_o = 1'b0;
        write_o = 1'b0;
        writedata_o = '0;
        byteenable_o = 4'hF;
        stuck_o = 1'b0;
    end

    // request rises just after a rising edge and stands until the rising
    // edge at which waitrequest is seen low; read data is taken there too
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
        int n;
        @(posedge clk_i);
        address_o <= a;
        writedata_o <= d;
        write_o <= wr;
        read_o <= !wr;
        q = '0;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (waitrequest_i == 1'b0) break;
        end
        if (n == 20) stuck_o = 1'b1;
        else q = readdata_i;
        write_o <= 1'b0;
        read_o <= 1'b0;
    endtask

    // write-hold goes up before any protected register is written;
    // a one in the oscillator-fail position leaves that flag alone
    task automatic held_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] q;
        xfer(1'b1, OFF_FLAGS, (32'h1 << FB_WHOLD) | (32'h1 << FB_OSC_FAIL), q);
        xfer(1'b1, a, d, q);
    endtask
endmodule

// [sim/tb_rfc_top.sv]
// Self-checking bench for the flag and update control block.
// Assumes shortened check window and square-wave half period.
`timescale 1ns/1ps
module tb_rfc_top;
    import rfc_pkg::*;
    localparam int CHK = 50;
    localparam int HALF = 8;
    localparam logic [DATA_W-1:0] OSC_FAIL_BIT = 32'h1 << FB_OSC_FAIL;
    localparam logic [DATA_W-1:0] PWRF = 32'h1 << FB_PWRF;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [ADDR_W-1:0] addr;
    logic rd;
    logic wr;
    logic [DATA_W-1:0] wdata;
    logic [BE_W-1:0] be;
    logic [DATA_W-1:0] rdata;
    logic wreq;
    logic osc_en = 1'b1;
    logic osc_run = 1'b0;
    logic osc_kept = 1'b0;
    logic plow = 1'b0;
    logic tick = 1'b0;
    logic int_w;
    logic osc_fail_w;
    logic stuck;
    int err_total = 0;
    int comparisons = 0;

    rfc_top #(.OSC_CHK(CHK), .SQ_HALF(HALF)) u_rfc_top (
        .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .osc_en_i(osc_en),
        .osc_running_i(osc_run), .osc_fail_kept_i(osc_kept), .power_low_i(plow),
        .sec_tick_i(tick), .int_o(int_w), .osc_fail_o(osc_fail_w)
    );
    rfc_host u_rfc_host (
        .clk_i(clk_i), .address_o(addr), .read_o(rd), .write_o(wr),
        .writedata_o(wdata), .byteenable_o(be), .readdata_i(rdata),
        .waitrequest_i(wreq), .stuck_o(stuck)
    );

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge stuck) begin
        err_total++;
        conclude();
    end

    task automatic chk(input string nm, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] q;
        u_rfc_host.xfer(1'b1, a, d, q);
    endtask

    task automatic rchk(input string nm, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] q;
        u_rfc_host.xfer(1'b0, a, '0, q);
        chk(nm, q, exp);
    endtask

    task automatic pulse_tick();
        @(posedge clk_i) tick <= 1'b1;
        repeat (4) @(posedge clk_i);
        tick <= 1'b0;
        cyc(5);
    endtask

    task automatic do_reset();
        @(posedge clk_i) rst_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        cyc(CHK + 20);
    endtask

    task automatic t_boot();
        rchk("flags", OFF_FLAGS, OSC_FAIL_BIT);
        chk("osc_fail_o", 32'(osc_fail_w), 32'h1);
        rchk("irq_stat", OFF_IRQ_STAT, 32'h1);
        rchk("unmapped", 5'h14, 32'h0);
        $display("done boot");
    endtask

    task automatic t_power();
        wreg(OFF_IRQ_MASK, 32'h3);
        cyc(3);
        chk("int_o", 32'(int_w), 32'h1);
        @(posedge clk_i) plow <= 1'b1;
        repeat (8) @(posedge clk_i);
        plow <= 1'b0;
        cyc(8);
        rchk("irq_stat", OFF_IRQ_STAT, 32'h3);
        rchk("flags", OFF_FLAGS, OSC_FAIL_BIT | PWRF);
        rchk("flags", OFF_FLAGS, OSC_FAIL_BIT);
        wreg(OFF_IRQ_STAT, 32'h3);
        cyc(3);
        chk("int_o", 32'(int_w), 32'h0);
        $display("done power");
    endtask

    task automatic t_oscclr();
        u_rfc_host.held_wr(OFF_FLAGS, 32'h0);
        rchk("flags", OFF_FLAGS, OSC_FAIL_BIT);
        // still set shortly before the transfer time runs out
        cyc(XFER_CYC - 50);
        rchk("flags", OFF_FLAGS, OSC_FAIL_BIT);
        cyc(150);
        rchk("flags", OFF_FLAGS, 32'h0);
        chk("osc_fail_o", 32'(osc_fail_w), 32'h0);
        rchk("irq_stat", OFF_IRQ_STAT, 32'h4);
        $display("done oscclr");
    endtask

    task automatic t_whold();
        u_rfc_host.held_wr(OFF_TIME, 32'h100);
        pulse_tick();
        pulse_tick();
        rchk("time", OFF_TIME, 32'h100);
        wreg(OFF_FLAGS, 32'h0);
        rchk("count", OFF_COUNT, 32'h2);
        cyc(XFER_CYC + 100);
        rchk("count", OFF_COUNT, 32'h100);
        rchk("time", OFF_TIME, 32'h100);
        $display("done whold");
    endtask

    task automatic t_rhold();
        u_rfc_host.held_wr(OFF_FLAGS, 32'h1 << FB_RHOLD);
        cyc(XFER_CYC + 100);
        pulse_tick();
        rchk("time", OFF_TIME, 32'h100);
        rchk("count", OFF_COUNT, 32'h101);
        u_rfc_host.held_wr(OFF_FLAGS, 32'h0);
        cyc(5);
        rchk("time", OFF_TIME, 32'h101);
        $display("done rhold");
    endtask

    task automatic t_cal();
        int n;
        logic v;
        wreg(OFF_IRQ_MASK, 32'h0);
        u_rfc_host.held_wr(OFF_FLAGS, 32'h1 << FB_CAL);
        rchk("flags", OFF_FLAGS, 32'h1 << FB_CAL);
        cyc(1);
        v = int_w;
        for (n = 0; n < 40 && int_w === v; n++) cyc(1);
        v = int_w;
        for (n = 0; n < 40 && int_w === v; n++) cyc(1);
        chk("half_period", 32'(n), 32'(HALF));
        if (n == 40) conclude();
        u_rfc_host.held_wr(OFF_FLAGS, 32'h0);
        cyc(4);
        chk("int_o", 32'(int_w), 32'h0);
        $display("done cal");
    endtask

    task automatic t_kept();
        // retained flag with a running oscillator: kept, no boot failure
        @(posedge clk_i);
        osc_kept <= 1'b1;
        osc_run <= 1'b1;
        do_reset();
        rchk("flags", OFF_FLAGS, OSC_FAIL_BIT);
        rchk("irq_stat", OFF_IRQ_STAT, 32'h0);
        cyc(200);
        rchk("flags", OFF_FLAGS, OSC_FAIL_BIT);
        chk("osc_fail_o", 32'(osc_fail_w), 32'h1);
        // a disabled oscillator is not a failure
        @(posedge clk_i);
        osc_en <= 1'b0;
        osc_run <= 1'b0;
        osc_kept <= 1'b0;
        do_reset();
        rchk("flags", OFF_FLAGS, 32'h0);
        chk("osc_fail_o", 32'(osc_fail_w), 32'h0);
        $display("done kept");
    endtask

    initial begin
        do_reset();
        t_boot();
        t_power();
        t_oscclr();
        t_whold();
        t_rhold();
        t_cal();
        t_kept();
        conclude();
    end
endmodule

// [verilog/rfc_pkg.sv]
// Constants, register map and shared types for the clock flag and update-control block.
// Assumes a single 20 MHz clock and a synchronous active-high reset standing for power-up.
//
// What this block does
// - At power-up, flag oscillator failure if enabled oscillator shows no activity in 5 ms.
// - Oscillator-fail flag persists across power cycles; only a host write may clear it.
// - Host clears oscillator-fail by writing zero; clear lands after the transfer time.
// - Power-fail flag clears on a flags read while the supply is no longer low, and at power-up.
// - While write-hold is one, host-visible time registers stop following the counters.
// - Write-hold falling after a time change copies registers into counters after transfer time.
// - Write-hold resets to zero at every power-up.
package rfc_pkg;

    localparam int CLK_HZ = 20_000_000;
    localparam int OSC_CHK_MS = 5;
    localparam int OSC_CHK_CYC = (OSC_CHK_MS * CLK_HZ + 999) / 1000;
    localparam int XFER_US = 40;
    localparam int XFER_CYC = (XFER_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int SQ_HZ = 512;
    localparam int SQ_HALF_CYC = CLK_HZ / (2 * SQ_HZ);
    localparam int SYNC_LAT = 2;

    localparam int CHK_W = 17;
    localparam int SQ_W = 15;
    localparam int XFER_W = 12;
    localparam int TIME_W = 32;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;

    // byte addresses of the registers
    localparam logic [ADDR_W-1:0] OFF_FLAGS = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_TIME = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_COUNT = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 5'h0C;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 5'h10;

    // fields of rtc_flags_control
    localparam int FB_RHOLD = 0;
    localparam int FB_WHOLD = 1;
    localparam int FB_CAL = 2;
    localparam int FB_OSC_FAIL = 4;
    localparam int FB_PWRF = 5;

    // interrupt status and mask bits
    localparam int IRQ_W = 3;
    localparam int IB_OSC_FAIL = 0;
    localparam int IB_PWRF = 1;
    localparam int IB_XFER = 2;

    // synchroniser lanes
    localparam int SY_W = 5;
    localparam int SY_TICK = 0;
    localparam int SY_PLOW = 1;
    localparam int SY_KEPT = 2;
    localparam int SY_RUN = 3;
    localparam int SY_EN = 4;

    typedef enum logic [1:0] {
        BOOT_LOAD,
        BOOT_CHECK,
        BOOT_RUN
    } rfc_boot_type;

endpackage

// [verilog/rfc_top.sv]
// Flag and update control of the real time clock, with an Avalon-MM register slave.
// Assumes oscillator, supply and tick inputs are asynchronous pins; rst_i is power-up.
`timescale 1ns/1ps
module rfc_top
    import rfc_pkg::*;
#(
    parameter int OSC_CHK = OSC_CHK_CYC,
    parameter int SQ_HALF = SQ_HALF_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [DATA_W-1:0] avs_writedata_i,
    input wire logic [BE_W-1:0] avs_byteenable_i,
    output logic [DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // oscillator and supply pins
    input wire logic osc_en_i,
    input wire logic osc_running_i,
    input wire logic osc_fail_kept_i,
    input wire logic power_low_i,
    input wire logic sec_tick_i,
    // outputs
    output logic int_o,
    output logic osc_fail_o
);

    typedef struct packed {
        logic [SY_W-1:0] s1;
        logic [SY_W-1:0] s2;
        logic tick_prev;
        logic plow_prev;
        rfc_boot_type boot;
        logic [CHK_W-1:0] chk_cnt;
        logic seen_run;
        logic osc_fail_flag;
        logic power_fail_flag;
        logic rhold;
        logic whold;
        logic cal;
        logic time_chg;
        logic copy_pend;
        logic clr_pend;
        logic copy_arm;
        logic clr_arm;
        logic [TIME_W-1:0] hold_time;
        logic [TIME_W-1:0] count;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [SQ_W-1:0] sq_cnt;
        logic sq;
        logic int_out;
        logic wait_q;
        logic [DATA_W-1:0] rdata;
    } rfc_state_type;

    localparam int XFER_LIM = XFER_CYC + 5;

    rfc_state_type q;
    rfc_state_type d;
    rfc_xfer_if xf ();

    logic req;
    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic boot_fail;

    function automatic logic [TIME_W-1:0] merge_lanes(input logic [TIME_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v, input logic [BE_W-1:0] be);
        logic [TIME_W-1:0] r;
        r = old_v;
        for (int i = 0; i < BE_W; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [DATA_W-1:0] read_word(input rfc_state_type s,
        input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] r;
        r = '0;
        case (a)
            OFF_FLAGS: begin
                r[FB_RHOLD] = s.rhold;
                r[FB_WHOLD] = s.whold;
                r[FB_CAL] = s.cal;
                r[FB_OSC_FAIL] = s.osc_fail_flag;
                r[FB_PWRF] = s.power_fail_flag;
            end
            OFF_TIME: r = s.hold_time;
            OFF_COUNT: r = s.count;
            OFF_IRQ_STAT: r[IRQ_W-1:0] = s.irq_stat;
            OFF_IRQ_MASK: r[IRQ_W-1:0] = s.irq_mask;
            default: r = '0;
        endcase
        return r;
    endfunction

    assign req = avs_read_i || avs_write_i;
    // a request is taken at the edge where waitrequest is seen low
    assign acc = req && !q.wait_q;
    assign wr_acc = acc && avs_write_i;
    assign rd_acc = acc && avs_read_i;
    // no new start while done is high, so arming never collides with applying
    assign xf.start = (q.copy_pend || q.clr_pend) && !xf.busy && !xf.done;
    // last cycle of the power-up window with an enabled but silent oscillator
    assign boot_fail = q.boot == BOOT_CHECK && q.chk_cnt == CHK_W'(OSC_CHK - 1)
        && q.s2[SY_EN] && !q.seen_run && !q.s2[SY_RUN];

    rfc_xfer u_xfer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .xf(xf)
    );

    always_comb begin
        d = q;
        d.s1 = {osc_en_i, osc_running_i, osc_fail_kept_i, power_low_i, sec_tick_i};
        d.s2 = q.s1;
        d.tick_prev = q.s2[SY_TICK];
        d.plow_prev = q.s2[SY_PLOW];

        // one wait cycle, then a single low cycle per request
        d.wait_q = !(req && q.wait_q);
        if (req && q.wait_q) begin
            d.rdata = read_word(q, avs_address_i);
        end

        // free-running seconds counter
        if (q.s2[SY_TICK] && !q.tick_prev) begin
            d.count = q.count + 1'b1;
        end

        case (q.boot)
            BOOT_LOAD: begin
                // retained flag is sampled once its synchroniser has filled
                d.chk_cnt = q.chk_cnt + 1'b1;
                if (q.chk_cnt == CHK_W'(SYNC_LAT)) begin
                    d.osc_fail_flag = q.s2[SY_KEPT];
                    d.chk_cnt = '0;
                    d.boot = BOOT_CHECK;
                end
            end
            BOOT_CHECK: begin
                d.chk_cnt = q.chk_cnt + 1'b1;
                if (q.s2[SY_RUN]) begin
                    d.seen_run = 1'b1;
                end
                // the failure itself is raised with the other events below
                if (q.chk_cnt == CHK_W'(OSC_CHK - 1)) begin
                    d.boot = BOOT_RUN;
                end
            end
            BOOT_RUN: d.chk_cnt = q.chk_cnt;
            default: d.boot = BOOT_RUN;
        endcase

        // freeze while any hold or pending copy is in force
        if (!q.whold && !q.rhold && !q.copy_pend && !q.copy_arm) begin
            d.hold_time = q.count;
        end

        if (xf.start) begin
            d.copy_arm = q.copy_pend;
            d.clr_arm = q.clr_pend;
            d.copy_pend = 1'b0;
            d.clr_pend = 1'b0;
        end
        if (xf.done) begin
            if (q.copy_arm) begin
                d.count = q.hold_time;
            end
            if (q.clr_arm) begin
                d.osc_fail_flag = 1'b0;
            end
            d.copy_arm = 1'b0;
            d.clr_arm = 1'b0;
            d.irq_stat[IB_XFER] = 1'b1;
        end

        if (wr_acc && avs_address_i == OFF_FLAGS && avs_byteenable_i[0]) begin
            d.rhold = avs_writedata_i[FB_RHOLD];
            d.whold = avs_writedata_i[FB_WHOLD];
            d.cal = avs_writedata_i[FB_CAL];
            if (q.whold && !avs_writedata_i[FB_WHOLD] && q.time_chg) begin
                d.copy_pend = 1'b1;
                d.time_chg = 1'b0;
            end
            // only a written zero acts; a written one is ignored
            if (q.osc_fail_flag && !avs_writedata_i[FB_OSC_FAIL]) begin
                d.clr_pend = 1'b1;
            end
        end
        // time writes only land while the registers are frozen
        if (wr_acc && avs_address_i == OFF_TIME && q.whold) begin
            d.hold_time = merge_lanes(q.hold_time, avs_writedata_i, avs_byteenable_i);
            d.time_chg = 1'b1;
        end
        if (wr_acc && avs_address_i == OFF_IRQ_MASK) begin
            d.irq_mask = avs_writedata_i[IRQ_W-1:0];
        end
        if (wr_acc && avs_address_i == OFF_IRQ_STAT) begin
            d.irq_stat = d.irq_stat & ~avs_writedata_i[IRQ_W-1:0];
        end

        // set wins over the read-clear
        if (rd_acc && avs_address_i == OFF_FLAGS) begin
            d.power_fail_flag = 1'b0;
        end
        if (q.s2[SY_PLOW]) begin
            d.power_fail_flag = 1'b1;
        end
        // events after the clear so that a coincident event is kept
        if (q.s2[SY_PLOW] && !q.plow_prev) begin
            d.irq_stat[IB_PWRF] = 1'b1;
        end
        if (xf.done) begin
            d.irq_stat[IB_XFER] = 1'b1;
        end
        // after the clears, so neither a host clear nor a W1C can lose it
        if (boot_fail) begin
            d.osc_fail_flag = 1'b1;
            d.irq_stat[IB_OSC_FAIL] = 1'b1;
        end

        if (!q.cal) begin
            d.sq_cnt = '0;
            d.sq = 1'b0;
        end else if (q.sq_cnt == SQ_W'(SQ_HALF - 1)) begin
            d.sq_cnt = '0;
            d.sq = !q.sq;
        end else begin
            d.sq_cnt = q.sq_cnt + 1'b1;
        end
        d.int_out = q.cal ? q.sq : |(q.irq_stat & q.irq_mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // power-up clears holds, calibration and power-fail
            q <= '0;
            q.wait_q <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign avs_readdata_o = q.rdata;
    assign avs_waitrequest_o = q.wait_q;
    assign int_o = q.int_out;
    assign osc_fail_o = q.osc_fail_flag;

    powerup_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> !q.whold && !q.cal && !q.power_fail_flag && !q.rhold)
        else $error("control bits not cleared at power-up");

    pwr_read_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_acc && avs_address_i == OFF_FLAGS && !q.s2[SY_PLOW] |=> !q.power_fail_flag)
        else $error("power-fail not cleared by flags read");

    osc_flag_kept_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q.boot == BOOT_RUN && q.osc_fail_flag && !(xf.done && q.clr_arm) |=> q.osc_fail_flag)
        else $error("oscillator-fail cleared without host");

    osc_clr_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_acc && avs_address_i == OFF_FLAGS && avs_byteenable_i[0]
        && !avs_writedata_i[FB_OSC_FAIL] && q.osc_fail_flag && q.boot == BOOT_RUN
        && !xf.busy && !xf.done && !q.copy_pend && !q.clr_pend
        |=> q.osc_fail_flag [*8] ##[1:XFER_LIM] !q.osc_fail_flag)
        else $error("oscillator-fail clear not applied after transfer time");

    osc_boot_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q.boot == BOOT_CHECK && q.chk_cnt == CHK_W'(OSC_CHK - 1) && q.s2[SY_EN]
        && !q.seen_run && !q.s2[SY_RUN] |=> q.osc_fail_flag && q.irq_stat[IB_OSC_FAIL])
        else $error("oscillator failure not flagged at power-up");

    whold_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q.whold && !(wr_acc && avs_address_i == OFF_TIME) |=> $stable(q.hold_time))
        else $error("time registers moved under write-hold");

    rhold_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q.rhold && !q.whold |=> q.hold_time == $past(q.hold_time))
        else $error("holding registers moved under read-hold");

    copy_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_acc && avs_address_i == OFF_FLAGS && avs_byteenable_i[0] && q.whold
        && !avs_writedata_i[FB_WHOLD] && q.time_chg |=> q.copy_pend || q.copy_arm)
        else $error("copy not requested after write-hold release");

    copy_apply_a: assert property (@(posedge clk_i) disable iff (rst_i)
        xf.done && q.copy_arm |=> q.count == $past(q.hold_time))
        else $error("counters not loaded from time registers");

    cal_square_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q.cal |=> int_o == $past(q.sq))
        else $error("interrupt output not carrying calibration wave");

endmodule

// [verilog/rfc_xfer.sv]
// Transfer timer: counts the rtc transfer time after each start and pulses done.
// Assumes start arrives only while busy and done are both low.
`timescale 1ns/1ps
module rfc_xfer
    import rfc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // handshake
    rfc_xfer_if.tmr xf
);

    typedef struct packed {
        logic busy;
        logic done;
        logic [XFER_W-1:0] cnt;
    } rfc_xfer_state_type;

    rfc_xfer_state_type q;
    rfc_xfer_state_type d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        if (q.busy) begin
            if (q.cnt == '0) begin
                d.busy = 1'b0;
                d.done = 1'b1;
            end else begin
                d.cnt = q.cnt - 1'b1;
            end
        end else if (xf.start) begin
            d.busy = 1'b1;
            d.cnt = XFER_W'(XFER_CYC - 1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign xf.busy = q.busy;
    assign xf.done = q.done;

    done_single_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        q.done |=> !q.done && !q.busy) else $error("transfer done longer than one cycle");

    busy_after_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        xf.start && !q.busy && !q.done |=> q.busy [*8]) else $error("transfer ended too early");

endmodule

// [verilog/rfc_xfer_if.sv]
// Handshake between the control logic and the transfer timer.
// Assumes both ends share one clock; start is only raised while the timer is idle.
`timescale 1ns/1ps
interface rfc_xfer_if;
    logic start;
    logic busy;
    logic done;

    modport ctl (
        output start,
        input busy,
        input done
    );

    modport tmr (
        input start,
        output busy,
        output done
    );
endinterface
